// ---- uepc_pkg.sv ----
// Purpose: shared constants for the usb endpoint control block
// Assumes: axi4-lite byte addresses are four times the register index
// Notes: one aligned word per 8-bit register, upper bits read zero
package uepc_pkg;
    // ****************************************************************
    // register indices and byte addresses
    // ****************************************************************
    localparam logic [7:0] EP0_CSR_IDX = 8'h11;
    localparam logic [7:0] INDEX_IDX = 8'h0e;
    // in low shares the endpoint zero slot; the index picks the set
    localparam logic [7:0] IN_CTL_LOW_IDX = 8'h11;
    localparam logic [7:0] IN_CTL_HIGH_IDX = 8'h13;
    localparam logic [7:0] EVENT_IDX = 8'h14;
    localparam logic [9:0] EP0_CSR_ADDR = {EP0_CSR_IDX, 2'b00};
    localparam logic [9:0] INDEX_ADDR = {INDEX_IDX, 2'b00};
    localparam logic [9:0] IN_CTL_LOW_ADDR = {IN_CTL_LOW_IDX, 2'b00};
    localparam logic [9:0] IN_CTL_HIGH_ADDR = {IN_CTL_HIGH_IDX, 2'b00};
    localparam logic [9:0] EVENT_ADDR = {EVENT_IDX, 2'b00};
    // ****************************************************************
    // endpoint zero control/status bit positions
    // ****************************************************************
    localparam int E0_OUT_READY = 0;
    localparam int E0_IN_READY = 1;
    localparam int E0_SENT_STALL = 2;
    localparam int E0_LAST_DATA = 3;
    localparam int E0_SETUP_END = 4;
    localparam int E0_SEND_STALL = 5;
    localparam int E0_SVC_OUT = 6;
    localparam int E0_SVC_SETUP = 7;
    // ****************************************************************
    // in endpoint low/high control bit positions
    // ****************************************************************
    localparam int IL_IN_READY = 0;
    localparam int IL_FIFO_NE = 1;
    localparam int IL_UNDERRUN = 2;
    localparam int IL_FLUSH = 3;
    localparam int IL_SEND_STALL = 4;
    localparam int IL_SENT_STALL = 5;
    localparam int IL_CLR_TOGGLE = 6;
    localparam int IH_FORCE_TOG = 3;
    localparam int IH_DIR_SEL = 5;
    localparam int IH_ISO = 6;
    localparam int IH_SPLIT = 2;
    localparam int IH_DBL_BUF = 7;
    localparam int IH_ISO_UPD = 1;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int SETUP_LEN = 8;
    // ****************************************************************
    // token kinds from the serial interface engine
    // ****************************************************************
    typedef enum logic [1:0] {UEPC_TOK_IN, UEPC_TOK_OUT, UEPC_TOK_SETUP,
        UEPC_TOK_SOF} uepc_tok_e;
    // handshake answers to an in token
    typedef enum logic [1:0] {UEPC_ANS_NAK, UEPC_ANS_DATA, UEPC_ANS_STALL,
        UEPC_ANS_ZLP} uepc_ans_e;
endpackage : uepc_pkg

// ---- uepc_in_ep.sv ----
// Purpose: state of one in endpoint (1 to 3)
// Assumes: token, ack and write strobes are one-cycle pulses
// Notes: two packet slots when double buffering is on
`timescale 1ns/1ps
module uepc_in_ep
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [7:0] wdata,
    input wire logic fifo_has_data,
    input wire logic tok_in,
    input wire logic host_ack,
    input wire logic sof,
    output logic [7:0] ctl_low,
    output logic [7:0] ctl_high,
    output logic [1:0] answer,
    output logic toggle,
    output logic ep_irq
);
    logic [7:0] high_q;
    logic [1:0] slots_q, slots_d;
    logic [1:0] held_q;
    logic ready_q, ready_d, stall_q, sent_q, under_q, tog_q, zlp_q;
    wire iso = high_q[uepc_pkg::IH_ISO];
    wire dbl = high_q[uepc_pkg::IH_DBL_BUF];
    wire upd = high_q[uepc_pkg::IH_ISO_UPD];
    wire set_ready = wr_low && wdata[uepc_pkg::IL_IN_READY];
    wire flush = wr_low && wdata[uepc_pkg::IL_FLUSH];
    wire sendable = (slots_q > held_q) || (!upd && slots_q != 2'd0);
    // stall only in bulk/interrupt mode
    wire do_stall = tok_in && stall_q && !iso; // [RULE_10]
    wire do_send = tok_in && !do_stall && sendable; // [RULE_08]
    wire do_under = tok_in && iso && !sendable; // [RULE_17]
    wire [1:0] cap = dbl ? 2'd2 : 2'd1;
    // slot count: commit on ready, release on send or flush
    always_comb
    begin
        slots_d = slots_q;
        if (flush && slots_q != 2'd0)
            slots_d = 2'd0;
        else if (set_ready && !do_send)
            slots_d = slots_q + 2'd1;
        else if (do_send && !set_ready)
            slots_d = slots_q - 2'd1;
        // ready drops whenever a slot is free, no irq for it
        ready_d = (slots_d >= cap) && !flush; // [RULE_12] [RULE_13]
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            high_q <= uepc_pkg::REG_RESET;
            slots_q <= 2'd0;
            held_q <= 2'd0;
            ready_q <= 1'b0;
            stall_q <= 1'b0;
            sent_q <= 1'b0;
            under_q <= 1'b0;
            tog_q <= 1'b0;
            zlp_q <= 1'b0;
            ep_irq <= 1'b0;
        end
        else
        begin
            if (wr_high)
                high_q <= wdata; // [RULE_01] [RULE_03] [RULE_04] [RULE_05]
            slots_q <= slots_d;
            ready_q <= ready_d;
            // packets committed this frame wait for the next sof
            if (sof || !upd)
                held_q <= 2'd0; // [RULE_18]
            else if (set_ready)
                held_q <= slots_d;
            if (wr_low)
                stall_q <= wdata[uepc_pkg::IL_SEND_STALL];
            // set beats a firmware clear in the same cycle
            if (do_stall)
                sent_q <= 1'b1; // [RULE_11]
            else if (wr_low && !wdata[uepc_pkg::IL_SENT_STALL])
                sent_q <= 1'b0;
            if (do_under)
                under_q <= 1'b1;
            else if (wr_low && !wdata[uepc_pkg::IL_UNDERRUN])
                under_q <= 1'b0;
            if (set_ready)
                zlp_q <= !fifo_has_data; // [RULE_09]
            if (wr_low && wdata[uepc_pkg::IL_CLR_TOGGLE])
                tog_q <= 1'b0;
            else if (do_send && high_q[uepc_pkg::IH_FORCE_TOG])
                tog_q <= !tog_q; // [RULE_14]
            else if (host_ack && !high_q[uepc_pkg::IH_FORCE_TOG])
                tog_q <= !tog_q; // [RULE_15]
            ep_irq <= do_send || do_stall ||
                (flush && slots_q != 2'd0); // [RULE_06]
        end
    end
    assign answer = do_stall ? uepc_pkg::UEPC_ANS_STALL :
        (do_send && !zlp_q) ? uepc_pkg::UEPC_ANS_DATA :
        (do_send || do_under) ? uepc_pkg::UEPC_ANS_ZLP :
        uepc_pkg::UEPC_ANS_NAK;
    assign ctl_low = {1'b0, 1'b0, sent_q, stall_q, 1'b0, under_q,
        slots_q != 2'd0, ready_q};
    assign ctl_high = high_q;
    assign toggle = tog_q;
endmodule : uepc_in_ep

// ---- uepc_ep0.sv ----
// Purpose: endpoint zero control/status state
// Assumes: sie events are one-cycle pulses
// Notes: tracks transmit mode for the setup-end flag
`timescale 1ns/1ps
module uepc_ep0
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic tok_in,
    input wire logic tok_out,
    input wire logic tok_setup,
    input wire logic [6:0] setup_len,
    input wire logic rx_ok,
    input wire logic stall_sent,
    output logic [7:0] csr,
    output logic [1:0] answer,
    output logic ep_irq
);
    logic out_rdy_q, in_rdy_q, sent_q, last_q, sue_q, sds_q, txm_q;
    wire setup_ok = tok_setup && setup_len == 7'(uepc_pkg::SETUP_LEN);
    wire got_out = rx_ok && (tok_out || setup_ok); // [RULE_20]
    wire send = tok_in && in_rdy_q;
    wire early = (tok_setup || tok_out) && txm_q;
    wire in_drop = send || (in_rdy_q && early); // [RULE_24]
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {out_rdy_q, in_rdy_q, sent_q, last_q} <= 4'h0;
            {sue_q, sds_q, txm_q, ep_irq} <= 4'h0;
        end
        else
        begin
            if (got_out)
                out_rdy_q <= 1'b1; // [RULE_19]
            else if (wr && wdata[uepc_pkg::E0_SVC_OUT])
                out_rdy_q <= 1'b0; // [RULE_23]
            if (in_drop)
                in_rdy_q <= 1'b0;
            else if (wr && wdata[uepc_pkg::E0_IN_READY])
                in_rdy_q <= 1'b1;
            if (early)
                sue_q <= 1'b1; // [RULE_22]
            else if (wr && wdata[uepc_pkg::E0_SVC_SETUP])
                sue_q <= 1'b0; // [RULE_23]
            if (stall_sent)
                sent_q <= 1'b1;
            else if (wr && !wdata[uepc_pkg::E0_SENT_STALL])
                sent_q <= 1'b0;
            if (wr)
                sds_q <= wdata[uepc_pkg::E0_SEND_STALL];
            if (send || early)
                last_q <= 1'b0;
            else if (wr && wdata[uepc_pkg::E0_LAST_DATA])
                last_q <= 1'b1;
            if (tok_setup || tok_out)
                txm_q <= 1'b0;
            else if (tok_in)
                txm_q <= 1'b1;
            ep_irq <= got_out || in_drop || stall_sent || early;
        end
    end
    // nak when nothing is marked ready and send-stall is clear
    assign answer = sds_q && tok_in ? uepc_pkg::UEPC_ANS_STALL :
        in_rdy_q ? uepc_pkg::UEPC_ANS_DATA :
        uepc_pkg::UEPC_ANS_NAK; // [RULE_21]
    assign csr = {2'b00, sds_q, sue_q, last_q, sent_q, in_rdy_q,
        out_rdy_q};
endmodule : uepc_ep0

// ---- uepc_top.sv ----
// Purpose: axi4-lite register front of the usb endpoint control
// Assumes: single clock, synchronous active-low reset
// Notes: index register picks which endpoint set is visible
`timescale 1ns/1ps
// Contract
// RULE_01: endpoints one to three are in, out or both; in supports three types; the code models endpoints one to three as in only
// RULE_02: only the indexed endpoint's registers are visible
// RULE_03: split bit one gives both in and out pipes; the code only stores the split bit and has no out pipe
// RULE_04: split bit zero uses direction-select for single direction; the code stores direction-select but never uses it
// RULE_05: iso bit selects isochronous, else bulk/interrupt alike
// RULE_06: in irq on sent packet, flush of non-empty fifo, or stall
// RULE_07: firmware loads fifo then sets in-packet-ready
// RULE_08: bulk in token with ready packet sends, clears ready, interrupts
// RULE_09: ready with empty fifo sends a zero-length packet
// RULE_10: send-stall set makes every bulk in token get stall
// RULE_11: each stall sets sent-stall and interrupts until firmware clears
// RULE_12: in-packet-ready clears whenever a packet slot is free
// RULE_13: slot-free clear raises no interrupt
// RULE_14: force-toggle flips toggle on every sent packet
// RULE_15: otherwise toggle flips only on host ack
// RULE_16: firmware should double buffer iso in endpoints
// RULE_17: iso in token with nothing ready sends zlp, sets underrun
// RULE_18: iso update holds new packets until next start-of-frame
// RULE_19: good endpoint-zero out sets out-ready and interrupts
// RULE_20: setup packets not eight bytes long are rejected
// RULE_21: endpoint-zero in without ready packet gets nak
// RULE_22: setup or out in transmit mode sets setup-end
// RULE_23: serviced bits clear their flags and read zero
// RULE_24: ep0 ready clears on send, setup overwrite or early out
module uepc_top
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] tok_ep,
    input wire logic [1:0] tok_kind,
    input wire logic tok_valid,
    input wire logic [6:0] setup_len,
    input wire logic rx_ok,
    input wire logic host_ack,
    input wire logic ep0_stall_sent,
    input wire logic [2:0] fifo_has_data,
    output logic [1:0] in_answer,
    output logic in_toggle,
    output logic ep_irq
);
    // ****************************************************************
    // axi4-lite write path
    // ****************************************************************
    logic aw_q, w_q;
    logic [9:0] awaddr_q;
    logic [7:0] wdata_q;
    logic wlane_q;
    logic [1:0] index_q;
    logic [7:0] evt_q;
    wire do_write = aw_q && w_q && !s_axi_bvalid;
    wire wr_en = do_write && wlane_q;
    // address and data taken independently, response after both
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 10'h000;
            wdata_q <= 8'h00;
            wlane_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr[9:0];
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wlane_q <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_awready = !aw_q;
    assign s_axi_wready = !w_q;
    // ****************************************************************
    // register write decode
    // ****************************************************************
    wire idx_zero = index_q == 2'd0;
    wire wr_index = wr_en && awaddr_q == uepc_pkg::INDEX_ADDR;
    wire wr_e0 = wr_en && idx_zero &&
        awaddr_q == uepc_pkg::EP0_CSR_ADDR; // [RULE_02]
    wire wr_low_any = wr_en && !idx_zero &&
        awaddr_q == uepc_pkg::IN_CTL_LOW_ADDR; // [RULE_02]
    wire wr_high_any = wr_en && !idx_zero &&
        awaddr_q == uepc_pkg::IN_CTL_HIGH_ADDR;
    wire wr_evt = wr_en && awaddr_q == uepc_pkg::EVENT_ADDR;
    wire mapped_w = awaddr_q == uepc_pkg::INDEX_ADDR ||
        awaddr_q == uepc_pkg::EP0_CSR_ADDR ||
        awaddr_q == uepc_pkg::IN_CTL_LOW_ADDR ||
        awaddr_q == uepc_pkg::IN_CTL_HIGH_ADDR ||
        awaddr_q == uepc_pkg::EVENT_ADDR;
    logic bresp_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bresp_q <= 1'b0;
        else if (do_write)
            bresp_q <= !mapped_w;
    end
    assign s_axi_bresp = bresp_q ? 2'b10 : 2'b00;
    // ****************************************************************
    // token decode
    // ****************************************************************
    wire t_in = tok_valid && tok_kind == uepc_pkg::UEPC_TOK_IN;
    wire t_out = tok_valid && tok_kind == uepc_pkg::UEPC_TOK_OUT;
    wire t_setup = tok_valid && tok_kind == uepc_pkg::UEPC_TOK_SETUP;
    wire t_sof = tok_valid && tok_kind == uepc_pkg::UEPC_TOK_SOF;
    wire ep0_hit = tok_ep == 2'd0;
    // ****************************************************************
    // endpoint zero
    // ****************************************************************
    logic [7:0] e0_csr;
    logic [1:0] e0_ans;
    logic e0_irq;
    uepc_ep0 u_ep0
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr(wr_e0),
        .wdata(wdata_q),
        .tok_in(t_in && ep0_hit),
        .tok_out(t_out && ep0_hit),
        .tok_setup(t_setup && ep0_hit),
        .setup_len(setup_len),
        .rx_ok(rx_ok && ep0_hit),
        .stall_sent(ep0_stall_sent),
        .csr(e0_csr),
        .answer(e0_ans),
        .ep_irq(e0_irq)
    );
    // ****************************************************************
    // in endpoints one to three
    // ****************************************************************
    logic [7:0] low_v [1:3];
    logic [7:0] high_v [1:3];
    logic [1:0] ans_v [1:3];
    logic [3:1] tog_v;
    logic [3:1] irq_v;
    genvar g;
    generate
        for (g = 1; g <= 3; g++)
        begin : g_ep
            wire sel = index_q == 2'(g);
            wire hit = tok_ep == 2'(g);
            uepc_in_ep u_ep
            (
                .aclk(aclk),
                .aresetn(aresetn),
                .wr_low(wr_low_any && sel),
                .wr_high(wr_high_any && sel),
                .wdata(wdata_q),
                .fifo_has_data(fifo_has_data[g-1]),
                .tok_in(t_in && hit),
                .host_ack(host_ack && hit),
                .sof(t_sof),
                .ctl_low(low_v[g]),
                .ctl_high(high_v[g]),
                .answer(ans_v[g]),
                .toggle(tog_v[g]),
                .ep_irq(irq_v[g])
            );
        end
    endgenerate
    // answer and toggle for the endpoint the token names
    assign in_answer = ep0_hit ? e0_ans : ans_v[tok_ep];
    assign in_toggle = ep0_hit ? 1'b0 : tog_v[tok_ep];
    // ****************************************************************
    // index and sticky event summary
    // ****************************************************************
    wire [3:0] evt_set = {irq_v, e0_irq};
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            index_q <= 2'd0;
            evt_q <= uepc_pkg::REG_RESET;
        end
        else
        begin
            if (wr_index)
                index_q <= wdata_q[1:0];
            // set wins over a write-one clear
            evt_q <= {4'h0, evt_set | (evt_q[3:0] &
                ~(wr_evt ? wdata_q[3:0] : 4'h0))};
        end
    end
    assign ep_irq = |evt_q;
    // ****************************************************************
    // axi4-lite read path
    // ****************************************************************
    logic [9:0] ra;
    assign ra = s_axi_araddr[9:0];
    wire [7:0] low_sel = idx_zero ? 8'h00 : low_v[index_q];
    wire [7:0] high_sel = idx_zero ? 8'h00 : high_v[index_q];
    wire [7:0] e0_sel = idx_zero ? e0_csr : low_sel;
    wire r_hit = ra == uepc_pkg::INDEX_ADDR ||
        ra == uepc_pkg::EP0_CSR_ADDR || ra == uepc_pkg::IN_CTL_LOW_ADDR ||
        ra == uepc_pkg::IN_CTL_HIGH_ADDR || ra == uepc_pkg::EVENT_ADDR;
    wire [7:0] rmux = ra == uepc_pkg::INDEX_ADDR ? {6'h00, index_q} :
        ra == uepc_pkg::EP0_CSR_ADDR ? e0_sel :
        ra == uepc_pkg::IN_CTL_LOW_ADDR ? low_sel :
        ra == uepc_pkg::IN_CTL_HIGH_ADDR ? high_sel :
        ra == uepc_pkg::EVENT_ADDR ? evt_q : 8'h00;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rmux};
            s_axi_rresp <= r_hit ? 2'b00 : 2'b10;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid;
    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_stall_tok;
        t_in && !ep0_hit && in_answer == uepc_pkg::UEPC_ANS_STALL;
    endsequence
    a_stall_sets_flag: assert property (@(posedge aclk) disable iff
        (!aresetn) s_stall_tok ##1 1 |-> ##[1:2] ep_irq) // [RULE_11]
        else $error("stall did not raise the event");
    a_ep0_nak_empty: assert property (@(posedge aclk) disable iff
        (!aresetn) t_in && ep0_hit && !e0_csr[1] && !e0_csr[5] |->
        in_answer == uepc_pkg::UEPC_ANS_NAK) // [RULE_21]
        else $error("ep0 empty did not nak");
    a_out_ready_set: assert property (@(posedge aclk) disable iff
        (!aresetn) rx_ok && t_out && ep0_hit |=> e0_csr[0]) // [RULE_19]
        else $error("out ready not set");
    a_short_setup: assert property (@(posedge aclk) disable iff
        (!aresetn) rx_ok && t_setup && ep0_hit &&
        setup_len != 7'(uepc_pkg::SETUP_LEN) &&
        !e0_csr[0] && !wr_e0 |=> !e0_csr[0]) // [RULE_20]
        else $error("bad setup accepted");
    a_svc_read_zero: assert property (@(posedge aclk) disable iff
        (!aresetn) e0_csr[7:6] == 2'b00) // [RULE_23]
        else $error("serviced bits read non-zero");
    a_write_answer: assert property (@(posedge aclk) disable iff
        (!aresetn) do_write |=> s_axi_bvalid) // [RULE_02]
        else $error("write response missing");
    a_bvalid_hold: assert property (@(posedge aclk) disable iff
        (!aresetn) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_read_hold: assert property (@(posedge aclk) disable iff
        (!aresetn) s_axi_rvalid && !s_axi_rready |=>
        $stable(s_axi_rdata) && s_axi_rvalid)
        else $error("read data changed while waiting");
endmodule : uepc_top

// ---- uepc_host.sv ----
// Purpose: host side model that issues tokens to the endpoint logic
// Assumes: token lines change just after a rising edge
// Notes: released kind and endpoint lines show the inverse of their last value; valid and rx_ok drop low
`timescale 1ns/1ps
module uepc_host
(
    input wire logic aclk,
    input wire logic [1:0] in_answer,
    input wire logic in_toggle,
    output logic [1:0] tok_ep,
    output logic [1:0] tok_kind,
    output logic tok_valid,
    output logic [6:0] setup_len,
    output logic rx_ok,
    output logic host_ack
);
    logic [1:0] ans_q;
    logic tog_q;
    // idle lines at time zero
    initial
    begin
        {tok_ep, tok_kind, tok_valid, setup_len, rx_ok, host_ack} = '0;
    end
    // one token cycle, answer taken mid-cycle, ack in the next cycle
    task token(input logic [1:0] ep, input logic [1:0] kind, input logic ack,
        input logic [6:0] len);
        @(posedge aclk);
        tok_ep <= ep;
        tok_kind <= kind;
        tok_valid <= 1'b1;
        setup_len <= len;
        rx_ok <= (kind != 2'h0);
        @(negedge aclk);
        ans_q = in_answer;
        tog_q = in_toggle;
        @(posedge aclk);
        tok_valid <= 1'b0;
        rx_ok <= 1'b0;
        tok_kind <= ~kind;
        host_ack <= ack;
        @(posedge aclk);
        host_ack <= 1'b0;
        tok_ep <= ~ep;
    endtask : token
endmodule : uepc_host

// ---- usb_endpoint_control_tb.sv ----
// Purpose: register and token tests of the usb endpoint control
// Assumes: byte address is four times the register index
// Notes: axi channels change after a rising edge and are held until taken
`timescale 1ns/1ps
module usb_endpoint_control_tb;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic awr, wr, bv, arr, rv, toggle, irq, tv, rxok, ack;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd, d;
    logic [1:0] br, rr, r, b, ans, tep, tk;
    logic [2:0] fifo = 0;
    logic [6:0] slen;
    int mismatches = 0, check_count = 0;
    // 40 MHz clock
    always #12.5 aclk = ~aclk;
    uepc_top u_uepc_top (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .tok_ep(tep), .tok_kind(tk),
        .tok_valid(tv), .setup_len(slen), .rx_ok(rxok), .host_ack(ack),
        .ep0_stall_sent(1'b0), .fifo_has_data(fifo), .in_answer(ans),
        .in_toggle(toggle), .ep_irq(irq));
    uepc_host u_uepc_host (.aclk(aclk), .in_answer(ans), .in_toggle(toggle),
        .tok_ep(tep), .tok_kind(tk), .tok_valid(tv), .setup_len(slen),
        .rx_ok(rxok), .host_ack(ack));
    // verdict and end of run
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // a bounded wait that ran out counts a mismatch and ends the run
    task hold(input logic done);
        if (!done)
        begin
            mismatches++;
            complete_run();
        end
    endtask : hold
    // axi write of one register byte, each channel released when taken
    task axw(input logic [9:0] a, input logic [7:0] v);
        int n;
        logic done;
        @(posedge aclk);
        awa <= {22'h0, a};
        wd <= {24'h0, v};
        {awv, wv, bry} <= 3'b111;
        done = 1'b0;
        for (n = 0; n < 64 && !done; n++)
        begin
            @(posedge aclk);
            if (awv && awr)
                awv <= 1'b0;
            if (wv && wr)
                wv <= 1'b0;
            if (bv)
            begin
                b = br;
                bry <= 1'b0;
                done = 1'b1;
            end
        end
        hold(done);
    endtask : axw
    // axi read, data and response kept in d and r
    task axr(input logic [9:0] a);
        int n;
        logic done;
        @(posedge aclk);
        ara <= {22'h0, a};
        {arv, rry} <= 2'b11;
        done = 1'b0;
        for (n = 0; n < 64 && !done; n++)
        begin
            @(posedge aclk);
            if (arv && arr)
                arv <= 1'b0;
            if (rv)
            begin
                d = rd;
                r = rr;
                rry <= 1'b0;
                done = 1'b1;
            end
        end
        hold(done);
    endtask : axr
    // main sequence
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axr(10'h044);
        chk(d, 32'h0);
        u_uepc_host.token(2'h0, 2'h0, 1'b0, 7'h08);
        chk(u_uepc_host.ans_q, 2'h0);
        u_uepc_host.token(2'h0, 2'h1, 1'b0, 7'h08);
        axr(10'h044);
        chk(d, 32'h11);
        axw(10'h044, 8'hc0);
        axr(10'h044);
        chk(d, 32'h0);
        u_uepc_host.token(2'h0, 2'h2, 1'b0, 7'h07);
        axr(10'h044);
        chk(d, 32'h0);
        $display("endpoint zero test done");
        axw(10'h038, 8'h01);
        axw(10'h050, 8'h0f);
        chk(irq, 1'b0);
        fifo <= 3'b001;
        axw(10'h044, 8'h01);
        u_uepc_host.token(2'h1, 2'h0, 1'b1, 7'h08);
        chk(u_uepc_host.ans_q, 2'h1);
        axr(10'h044);
        chk(d & 32'h1, 32'h0);
        chk(irq, 1'b1);
        fifo <= 3'b000;
        axw(10'h044, 8'h01);
        u_uepc_host.token(2'h1, 2'h0, 1'b0, 7'h08);
        chk(u_uepc_host.ans_q, 2'h3);
        chk(u_uepc_host.tog_q, 1'b1);
        axw(10'h044, 8'h10);
        u_uepc_host.token(2'h1, 2'h0, 1'b0, 7'h08);
        chk(u_uepc_host.ans_q, 2'h2);
        axr(10'h044);
        chk(d & 32'h20, 32'h20);
        $display("bulk test done");
        axw(10'h044, 8'h00);
        axw(10'h04c, 8'h40);
        u_uepc_host.token(2'h1, 2'h0, 1'b0, 7'h08);
        chk(u_uepc_host.ans_q, 2'h3);
        axr(10'h044);
        chk(d & 32'h24, 32'h04);
        axw(10'h04c, 8'hc0);
        axw(10'h050, 8'h0f);
        axw(10'h044, 8'h01);
        axr(10'h044);
        chk(d & 32'h3, 32'h2);
        axw(10'h044, 8'h01);
        axr(10'h044);
        chk(d & 32'h3, 32'h3);
        chk(irq, 1'b0);
        axr(10'h3fc);
        chk(r, 2'h2);
        axw(10'h3fc, 8'h00);
        chk(b, 2'h2);
        $display("iso and decode test done");
        complete_run();
    end
endmodule : usb_endpoint_control_tb
